/* File: acdiv_pkg.sv */
// Shared constants and types of the input clock divider and front-end control block.
package acdiv_pkg;

    // ************************************************************
    // Serial register port framing
    // ************************************************************
    localparam int          ADDR_W     = 15;
    localparam int          DATA_W     = 8;
    localparam logic [4:0]  INSTR_LAST = 5'h0f;  // Bit count of the last instruction bit.
    localparam logic [4:0]  FRAME_LAST = 5'h17;  // Bit count of the last data bit.

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [14:0] OFF_BUF_CURRENT = 15'h0018;
    localparam logic [14:0] OFF_REF_SELECT  = 15'h0024;
    localparam logic [14:0] OFF_DIV_RATIO   = 15'h010b;
    localparam logic [14:0] OFF_SYNC_CTRL   = 15'h010d;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BUF_A_LSB     = 0;  // Channel A buffer current code, bits 3:0.
    localparam int BUF_B_LSB     = 4;  // Channel B buffer current code, bits 7:4.
    localparam int BUF_W         = 4;
    localparam int REF_EXT_BIT   = 0;  // One selects the external reference.
    localparam int RATIO_W       = 2;  // Divide code in bits 1:0.
    localparam int PHASE_W       = 3;  // Divider load state in bits 2:0.
    localparam int SYNC_SEEN_BIT = 6;  // Sticky flag, write one to clear.
    localparam int SYNC_EN_BIT   = 7;  // Enables alignment by the sync pulse.

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_BUF_CURRENT = 8'h00;
    localparam logic [7:0] RST_REF_SELECT  = 8'h00;
    localparam logic [7:0] RST_DIV_RATIO   = 8'h00;
    localparam logic [7:0] RST_SYNC_CTRL   = 8'h00;

    // ************************************************************
    // Divide ratio codes
    // ************************************************************
    localparam logic [1:0] DIV1 = 2'h0;
    localparam logic [1:0] DIV2 = 2'h1;
    localparam logic [1:0] DIV4 = 2'h2;
    localparam logic [1:0] DIV8 = 2'h3;

    // ************************************************************
    // Serial frame states
    // ************************************************************
    typedef enum logic [3:0] {
        SPI_IDLE  = 4'b0001,
        SPI_INSTR = 4'b0010,
        SPI_DATA  = 4'b0100,
        SPI_DONE  = 4'b1000
    } acdiv_spi_state_t;

endpackage

/* File: acdiv_divider.sv */
// Divider of the sampled input clock producing the conversion clock.
module acdiv_divider (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       in_level,
    input  wire logic       in_rise,
    input  wire logic [1:0] ratio_code,
    input  wire logic       sync_load,
    input  wire logic [2:0] sync_phase,
    output logic            conv_clk,
    output logic            conv_rise
);

    typedef struct packed {
        logic [2:0] phase;
        logic       conv;
        logic       rise;
    } acdiv_div_state_t;

    acdiv_div_state_t s_reg;
    acdiv_div_state_t s_next;

    // Returns the last phase of a divide period, one less than the ratio.
    function automatic logic [2:0] last_phase(input logic [1:0] code);
        if (code == acdiv_pkg::DIV2) begin
            return 3'h1;
        end else if (code == acdiv_pkg::DIV4) begin
            return 3'h3;
        end else if (code == acdiv_pkg::DIV8) begin
            return 3'h7;
        end
        return 3'h0;
    endfunction

    // Output is high for the first half of the phases, which makes the duty exactly half.
    function automatic logic high_half(input logic [2:0] ph, input logic [1:0] code);
        logic [3:0] half;
        half = ({1'b0, last_phase(code)} + 4'h1) >> 1;
        return {1'b0, ph} < half;
    endfunction

    logic [2:0] mask;
    logic [2:0] step;
    assign mask = last_phase(ratio_code);
    assign step = (s_reg.phase >= mask) ? 3'h0 : s_reg.phase + 3'h1;

    // Next state: pass through at ratio one, else count input rising edges.
    always_comb begin
        s_next      = s_reg;
        s_next.rise = 1'b0;
        if (ratio_code == acdiv_pkg::DIV1) begin
            // Parking on the last phase makes the first rise after leaving ratio one open a high half.
            s_next.phase = 3'h7;
            s_next.conv  = in_level;
            s_next.rise  = in_rise;
        end else if (sync_load) begin
            s_next.phase = sync_phase & mask;
            s_next.conv  = high_half(sync_phase & mask, ratio_code);
            s_next.rise  = s_next.conv & ~s_reg.conv;
        end else if (in_rise) begin
            s_next.phase = step;
            s_next.conv  = high_half(step, ratio_code);
            s_next.rise  = s_next.conv & ~s_reg.conv;
        end
    end

    // State register.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign conv_clk  = s_reg.conv;
    assign conv_rise = s_reg.rise;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    AST_DIV1_FOLLOW: assert property ((ratio_code == acdiv_pkg::DIV1) && in_rise |=> conv_clk && conv_rise)
        else $error("Ratio one output did not follow the input rise.");
    AST_SYNC_LOAD: assert property ((ratio_code != acdiv_pkg::DIV1) && sync_load
        |=> s_reg.phase == ($past(sync_phase) & $past(mask)))
        else $error("Sync pulse did not load the divider state.");
    AST_DUTY: assert property ((ratio_code == acdiv_pkg::DIV2) && in_rise && !sync_load
        |=> conv_clk != $past(conv_clk))
        else $error("Divide by two output did not toggle on an input rise.");
    AST_RISE: assert property (conv_rise |-> conv_clk && !$past(conv_clk))
        else $error("Sample strobe without a conversion clock rise.");
    AST_DIV8: assert property ((ratio_code == acdiv_pkg::DIV8) && in_rise && !sync_load && s_reg.phase == 3'h7
        |=> s_reg.phase == 3'h0 && conv_clk)
        else $error("Divide by eight did not wrap to a high phase.");

endmodule

/* File: acdiv_top.sv */
// Input clock divider with serial register port and front-end configuration outputs.
//
// Operation
// - Divide the sampled input clock by one, two, four or eight.
// - Divide ratio comes from the register at offset 0x10B.
// - Valid sync pulse loads the divider with a programmed state, except at ratio one.
// - Sync alignment only while bit 7 of offset 0x10D is one.
// - Divided clock has half duty whenever the ratio exceeds one.
// - Register 0x024 selects internal or external reference.
// - Register 0x018 sets buffer current separately per channel.
// - Sampling happens on the conversion clock rising edge.
module acdiv_top (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic spi_clk,
    input  wire logic spi_cs_b,
    input  wire logic spi_data_in,
    output logic      spi_data_out,
    output logic      spi_data_oe_b,
    input  wire logic sample_clk_in,
    input  wire logic sysref_in,
    output logic      conv_clk,
    output logic      conv_sample,
    output logic [3:0] buf_current_a,
    output logic [3:0] buf_current_b,
    output logic      ref_external
);

    typedef struct packed {
        logic [2:0]                  sclk_s;
        logic [2:0]                  csb_s;
        logic [2:0]                  sdio_s;
        logic [2:0]                  sysref_s;
        logic [2:0]                  smp_s;
        logic                        sclk_f;
        logic                        csb_f;
        logic                        sdio_f;
        logic                        sysref_f;
        logic                        smp_f;
        acdiv_pkg::acdiv_spi_state_t st;
        logic [4:0]                  bitcnt;
        logic [15:0]                 shift;
        logic [14:0]                 addr;
        logic                        rd;
        logic [7:0]                  rdata;
        logic                        dout;
        logic                        doe_b;
        logic [7:0]                  buf_cur;
        logic [7:0]                  ref_sel;
        logic [7:0]                  div_ratio;
        logic [7:0]                  sync_ctl;
        logic                        sync_seen;
    } acdiv_top_state_t;

    acdiv_top_state_t s_reg;
    acdiv_top_state_t s_next;

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Filtered pin level: a change counts once the second and third stages agree.
    function automatic logic filt(input logic [2:0] sh, input logic prev);
        return (sh[1] == sh[2]) ? sh[2] : prev;
    endfunction

    // Read data for an address; unmapped addresses read as zero.
    function automatic logic [7:0] read_mux(input logic [14:0] a, input acdiv_top_state_t st);
        logic [7:0] v;
        v = 8'h00;
        if (a == acdiv_pkg::OFF_BUF_CURRENT) begin
            v = st.buf_cur;
        end else if (a == acdiv_pkg::OFF_REF_SELECT) begin
            v = st.ref_sel;
        end else if (a == acdiv_pkg::OFF_DIV_RATIO) begin
            v = st.div_ratio;
        end else if (a == acdiv_pkg::OFF_SYNC_CTRL) begin
            v = st.sync_ctl;
            v[acdiv_pkg::SYNC_SEEN_BIT] = st.sync_seen;
        end
        return v;
    endfunction

    // ************************************************************
    // Pin filtering and event detection
    // ************************************************************
    logic        sclk_now;
    logic        csb_now;
    logic        sdio_now;
    logic        sysref_now;
    logic        smp_now;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        sysref_rise;
    logic        smp_rise;
    logic        sync_load;
    logic        wr_en;
    logic [7:0]  wr_data;
    logic [15:0] instr;
    logic        div_clk;
    logic        div_rise;

    // Filtered levels and their edges, one cycle ahead of the stored copies.
    assign sclk_now    = filt(s_reg.sclk_s, s_reg.sclk_f);
    assign csb_now     = filt(s_reg.csb_s, s_reg.csb_f);
    assign sdio_now    = filt(s_reg.sdio_s, s_reg.sdio_f);
    assign sysref_now  = filt(s_reg.sysref_s, s_reg.sysref_f);
    assign smp_now     = filt(s_reg.smp_s, s_reg.smp_f);
    assign sclk_rise   = sclk_now & ~s_reg.sclk_f;
    assign sclk_fall   = ~sclk_now & s_reg.sclk_f;
    assign sysref_rise = sysref_now & ~s_reg.sysref_f;
    assign smp_rise    = smp_now & ~s_reg.smp_f;

    // A sync pulse acts on the divider only while alignment is enabled.
    assign sync_load = sysref_rise & s_reg.sync_ctl[acdiv_pkg::SYNC_EN_BIT];

    // A write completes on the last data bit of a write frame.
    assign instr   = {s_reg.shift[14:0], sdio_now};
    assign wr_data = instr[7:0];
    assign wr_en   = (s_reg.st == acdiv_pkg::SPI_DATA) && sclk_rise && !s_reg.rd
                   && (s_reg.bitcnt == acdiv_pkg::FRAME_LAST);

    // ************************************************************
    // Next state
    // ************************************************************

    // Serial frame handling, register writes and the sticky sync flag.
    always_comb begin
        s_next          = s_reg;
        s_next.sclk_s   = {s_reg.sclk_s[1:0], spi_clk};
        s_next.csb_s    = {s_reg.csb_s[1:0], spi_cs_b};
        s_next.sdio_s   = {s_reg.sdio_s[1:0], spi_data_in};
        s_next.sysref_s = {s_reg.sysref_s[1:0], sysref_in};
        s_next.smp_s    = {s_reg.smp_s[1:0], sample_clk_in};
        s_next.sclk_f   = sclk_now;
        s_next.csb_f    = csb_now;
        s_next.sdio_f   = sdio_now;
        s_next.sysref_f = sysref_now;
        s_next.smp_f    = smp_now;
        if (csb_now) begin
            s_next.st     = acdiv_pkg::SPI_IDLE;
            s_next.bitcnt = 5'h00;
            s_next.doe_b  = 1'b1;
        end else begin
            case (s_reg.st)
                acdiv_pkg::SPI_IDLE: begin
                    s_next.st     = acdiv_pkg::SPI_INSTR;
                    s_next.bitcnt = 5'h00;
                end
                acdiv_pkg::SPI_INSTR: begin
                    if (sclk_rise) begin
                        s_next.shift  = instr;
                        s_next.bitcnt = s_reg.bitcnt + 5'h01;
                        if (s_reg.bitcnt == acdiv_pkg::INSTR_LAST) begin
                            s_next.st    = acdiv_pkg::SPI_DATA;
                            s_next.rd    = instr[15];
                            s_next.addr  = instr[14:0];
                            s_next.rdata = read_mux(instr[14:0], s_reg);
                        end
                    end
                end
                acdiv_pkg::SPI_DATA: begin
                    if (sclk_rise) begin
                        s_next.shift  = instr;
                        s_next.bitcnt = s_reg.bitcnt + 5'h01;
                        if (s_reg.bitcnt == acdiv_pkg::FRAME_LAST) begin
                            s_next.st = acdiv_pkg::SPI_DONE;
                        end
                    end else if (sclk_fall && s_reg.rd) begin
                        s_next.dout  = s_reg.rdata[7];
                        s_next.rdata = {s_reg.rdata[6:0], 1'b0};
                        s_next.doe_b = 1'b0;
                    end
                end
                acdiv_pkg::SPI_DONE: begin
                    s_next.st = acdiv_pkg::SPI_DONE;
                end
                default: begin
                    s_next.st = acdiv_pkg::SPI_IDLE;
                end
            endcase
        end
        if (wr_en) begin
            if (s_reg.addr == acdiv_pkg::OFF_BUF_CURRENT) begin
                s_next.buf_cur = wr_data;
            end else if (s_reg.addr == acdiv_pkg::OFF_REF_SELECT) begin
                s_next.ref_sel = wr_data;
            end else if (s_reg.addr == acdiv_pkg::OFF_DIV_RATIO) begin
                s_next.div_ratio = wr_data;
            end else if (s_reg.addr == acdiv_pkg::OFF_SYNC_CTRL) begin
                s_next.sync_ctl = wr_data;
                if (wr_data[acdiv_pkg::SYNC_SEEN_BIT]) begin
                    s_next.sync_seen = 1'b0;
                end
            end
        end
        // Setting the flag comes last, so a pulse in the clearing cycle is kept.
        if (sync_load) begin
            s_next.sync_seen = 1'b1;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_reg           <= '0;
            s_reg.st        <= acdiv_pkg::SPI_IDLE;
            s_reg.csb_s     <= 3'h7;
            s_reg.csb_f     <= 1'b1;
            s_reg.doe_b     <= 1'b1;
            s_reg.buf_cur   <= acdiv_pkg::RST_BUF_CURRENT;
            s_reg.ref_sel   <= acdiv_pkg::RST_REF_SELECT;
            s_reg.div_ratio <= acdiv_pkg::RST_DIV_RATIO;
            s_reg.sync_ctl  <= acdiv_pkg::RST_SYNC_CTRL;
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // Divider and outputs
    // ************************************************************

    // Divider core, steered by the ratio and sync registers.
    acdiv_divider u_div (
        .clock      (clock),
        .rst_b      (rst_b),
        .in_level   (smp_now),
        .in_rise    (smp_rise),
        .ratio_code (s_reg.div_ratio[acdiv_pkg::RATIO_W-1:0]),
        .sync_load  (sync_load),
        .sync_phase (s_reg.sync_ctl[acdiv_pkg::PHASE_W-1:0]),
        .conv_clk   (div_clk),
        .conv_rise  (div_rise)
    );

    // Register-backed outputs.
    assign conv_clk      = div_clk;
    assign conv_sample   = div_rise;
    assign spi_data_out  = s_reg.dout;
    assign spi_data_oe_b = s_reg.doe_b;
    assign buf_current_a = s_reg.buf_cur[acdiv_pkg::BUF_A_LSB +: acdiv_pkg::BUF_W];
    assign buf_current_b = s_reg.buf_cur[acdiv_pkg::BUF_B_LSB +: acdiv_pkg::BUF_W];
    assign ref_external  = s_reg.ref_sel[acdiv_pkg::REF_EXT_BIT];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    AST_RATIO_WRITE: assert property (wr_en && s_reg.addr == acdiv_pkg::OFF_DIV_RATIO
        |=> s_reg.div_ratio == $past(wr_data))
        else $error("Ratio write was not stored.");
    AST_SYNC_GATE: assert property (sysref_rise && !s_reg.sync_ctl[acdiv_pkg::SYNC_EN_BIT] |-> !sync_load)
        else $error("Divider loaded while alignment disabled.");
    AST_SEEN: assert property (sync_load |=> s_reg.sync_seen)
        else $error("Sync event did not set the sticky flag.");
    AST_REF: assert property (wr_en && s_reg.addr == acdiv_pkg::OFF_REF_SELECT
        |=> s_reg.ref_sel == $past(wr_data) && ref_external == $past(wr_data[acdiv_pkg::REF_EXT_BIT]))
        else $error("Reference select write not reflected.");
    AST_BUF: assert property (wr_en && s_reg.addr == acdiv_pkg::OFF_BUF_CURRENT
        |=> s_reg.buf_cur == $past(wr_data))
        else $error("Buffer current write was not stored.");

    COV_RATIO_WRITE: cover property (wr_en && s_reg.addr == acdiv_pkg::OFF_DIV_RATIO);
    COV_SYNC: cover property (sync_load && s_reg.div_ratio[1:0] == acdiv_pkg::DIV8);
    COV_READ: cover property (s_reg.st == acdiv_pkg::SPI_DATA && s_reg.rd ##1 !spi_data_oe_b);

endmodule

/* File: acdiv_clk_src.sv */
// Model of the external sample clock source and alignment pulse generator.
module acdiv_clk_src #(
    parameter int HIGH_CYC = 4,
    parameter int PERIOD   = 16
) (
    input  wire logic clock,
    input  wire logic run,
    input  wire logic sysref_req,
    output logic      sample_clk_in,
    output logic      sysref_in
);
    timeunit 1ns;
    timeprecision 1ps;

    int phase_cnt;
    int pulse_cnt;

    // Outputs start low so the pin filters see a clean idle level.
    initial begin
        sample_clk_in = 1'b0;
        sysref_in = 1'b0;
        phase_cnt = 0;
        pulse_cnt = 0;
    end

    // Clock stands still low while stopped; uneven duty when running, far below the divider limit.
    always @(posedge clock) begin
        if (run) begin
            sample_clk_in <= (phase_cnt < HIGH_CYC);
            phase_cnt     <= (phase_cnt == PERIOD - 1) ? 0 : phase_cnt + 1;
        end else begin
            sample_clk_in <= 1'b0;
            phase_cnt     <= 0;
        end
    end

    // Alignment pulse is stretched so that it outlasts the pin filter.
    always @(posedge clock) begin
        if (sysref_req) begin
            pulse_cnt <= 8;
        end else if (pulse_cnt > 0) begin
            pulse_cnt <= pulse_cnt - 1;
        end
        sysref_in <= sysref_req || (pulse_cnt > 1);
    end
endmodule

/* File: tb.sv */
// Self-checking testbench of the input clock divider and its register port.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clock = 1'b0;
    logic       rst_b = 1'b0;
    logic       spi_clk = 1'b0;
    logic       spi_cs_b = 1'b1;
    logic       spi_data_in = 1'b0;
    logic       spi_data_out;
    logic       spi_data_oe_b;
    logic       sample_clk_in;
    logic       sysref_in;
    logic       conv_clk;
    logic       conv_sample;
    logic [3:0] buf_current_a;
    logic [3:0] buf_current_b;
    logic       ref_external;
    logic       run = 1'b0;
    logic       sysref_req = 1'b0;
    int         err_total = 0;
    int         cmp_count = 0;
    int         cycle_cnt = 0;

    acdiv_top u_acdiv_top (
        .clock(clock), .rst_b(rst_b), .spi_clk(spi_clk), .spi_cs_b(spi_cs_b), .spi_data_in(spi_data_in),
        .spi_data_out(spi_data_out), .spi_data_oe_b(spi_data_oe_b), .sample_clk_in(sample_clk_in),
        .sysref_in(sysref_in), .conv_clk(conv_clk), .conv_sample(conv_sample),
        .buf_current_a(buf_current_a), .buf_current_b(buf_current_b), .ref_external(ref_external)
    );

    acdiv_clk_src u_acdiv_clk_src (
        .clock(clock), .run(run), .sysref_req(sysref_req), .sample_clk_in(sample_clk_in), .sysref_in(sysref_in)
    );

    // ************************************************************
    // Clock, timeout and reporting
    // ************************************************************
    // Free-running 25 MHz system clock.
    initial begin
        forever #20 clock = ~clock;
    end

    // A hung run counts as a mismatch and ends in the closing report.
    always @(posedge clock) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 60000) begin
            err_total = err_total + 1;
            $display("ERROR at %0t: run did not finish in time", $time);
            conclude();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compares one observed value with its expectation.
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // ************************************************************
    // Serial register port tasks
    // ************************************************************
    // One whole 24-bit frame; the host's data line toggles while the device answers.
    task automatic spi_frame(input logic rw, input logic [14:0] addr, input logic [7:0] wd, output logic [7:0] rd);
        logic [23:0] word;
        word = {rw, addr, wd};
        rd = 8'h00;
        @(posedge clock);
        spi_cs_b <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_data_in <= (rw && i < 8) ? ~spi_data_in : word[i];
            repeat (5) @(posedge clock);
            @(negedge clock);
            if (rw && i < 8) begin
                rd[i] = spi_data_out;
                check({15'h0000, spi_data_oe_b}, 16'h0000, "read drive enable");
            end
            @(posedge clock);
            spi_clk <= 1'b1;
            repeat (6) @(posedge clock);
            spi_clk <= 1'b0;
        end
        repeat (6) @(posedge clock);
        spi_cs_b <= 1'b1;
        repeat (8) @(posedge clock);
    endtask

    // Register write.
    task automatic wr(input logic [14:0] addr, input logic [7:0] data);
        logic [7:0] unused;
        spi_frame(1'b0, addr, data, unused);
    endtask

    // Register read compared with an expected byte.
    task automatic rd_chk(input logic [14:0] addr, input logic [7:0] exp, input string what);
        logic [7:0] got;
        spi_frame(1'b1, addr, 8'h00, got);
        check({8'h00, got}, {8'h00, exp}, what);
    endtask

    // ************************************************************
    // Divider helpers
    // ************************************************************
    // Waits, bounded, for the next sample pulse.
    task automatic wait_sample();
        for (int k = 0; k < 2000; k++) begin
            @(negedge clock);
            if (conv_sample === 1'b1) begin
                break;
            end
        end
    endtask

    // Fires one alignment pulse and lets it pass the pin filter.
    task automatic fire_sync();
        @(posedge clock);
        sysref_req <= 1'b1;
        @(posedge clock);
        sysref_req <= 1'b0;
        repeat (24) @(posedge clock);
    endtask

    // Measures period and high time of the conversion clock, in system clocks.
    task automatic measure(input logic [1:0] code, input int n);
        int per;
        int hi;
        per = 0;
        hi = 0;
        wr(acdiv_pkg::OFF_DIV_RATIO, {6'h00, code});
        run <= 1'b1;
        repeat (3) wait_sample();
        do begin
            hi = hi + (conv_clk === 1'b1);
            per = per + 1;
            @(negedge clock);
        end while (conv_sample !== 1'b1 && per < 2000);
        check(per[15:0], 16'(n * 16), "conversion period");
        check(hi[15:0], 16'((n == 1) ? 4 : n * 8), "conversion high time");
        @(posedge clock);
        run <= 1'b0;
        repeat (40) @(posedge clock);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        int rises;
        logic prev;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (6) @(posedge clock);
        check({9'h000, conv_clk, buf_current_a, buf_current_b, ref_external, spi_data_oe_b}, 16'h0001, "reset outputs");
        rd_chk(acdiv_pkg::OFF_BUF_CURRENT, acdiv_pkg::RST_BUF_CURRENT, "reset buffer current");
        rd_chk(acdiv_pkg::OFF_REF_SELECT, acdiv_pkg::RST_REF_SELECT, "reset reference");
        rd_chk(acdiv_pkg::OFF_DIV_RATIO, acdiv_pkg::RST_DIV_RATIO, "reset ratio");
        rd_chk(acdiv_pkg::OFF_SYNC_CTRL, acdiv_pkg::RST_SYNC_CTRL, "reset sync control");
        $display("test reset values done");

        // Channel codes chosen for a mid-band input on A and a high-band input on B.
        wr(acdiv_pkg::OFF_BUF_CURRENT, 8'h93);
        check({8'h00, buf_current_b, buf_current_a}, 16'h0093, "buffer current split");
        wr(acdiv_pkg::OFF_REF_SELECT, 8'h01);
        check({15'h0000, ref_external}, 16'h0001, "external reference");
        rd_chk(acdiv_pkg::OFF_BUF_CURRENT, 8'h93, "buffer current read");
        wr(15'h0100, 8'hff);
        rd_chk(15'h0100, 8'h00, "unmapped read");
        rd_chk(acdiv_pkg::OFF_REF_SELECT, 8'h01, "reference after unmapped write");
        wr(acdiv_pkg::OFF_REF_SELECT, 8'h00);
        check({15'h0000, ref_external}, 16'h0000, "internal reference");
        $display("test front-end registers done");

        for (int c = 0; c < 4; c++) begin
            measure(c[1:0], 1 << c);
        end
        $display("test divide ratios done");

        // Input clock is stopped, ratio is eight; loads show directly on the conversion clock.
        wr(acdiv_pkg::OFF_SYNC_CTRL, 8'h81);
        fire_sync();
        check({15'h0000, conv_clk}, 16'h0001, "load phase one");
        rd_chk(acdiv_pkg::OFF_SYNC_CTRL, 8'hc1, "sticky after sync");
        wr(acdiv_pkg::OFF_SYNC_CTRL, 8'hc5);
        rd_chk(acdiv_pkg::OFF_SYNC_CTRL, 8'h85, "sticky cleared");
        fire_sync();
        check({15'h0000, conv_clk}, 16'h0000, "load phase five");
        wr(acdiv_pkg::OFF_SYNC_CTRL, 8'h41);
        fire_sync();
        check({15'h0000, conv_clk}, 16'h0000, "sync ignored when disabled");
        rd_chk(acdiv_pkg::OFF_SYNC_CTRL, 8'h01, "no sticky when disabled");
        rises = 0;
        prev = 1'b0;
        run <= 1'b1;
        for (int k = 0; k < 1000; k++) begin
            @(negedge clock);
            if (sample_clk_in === 1'b1 && prev === 1'b0) begin
                rises = rises + 1;
            end
            prev = sample_clk_in;
            if (conv_sample === 1'b1) begin
                break;
            end
        end
        check(rises[15:0], 16'h0003, "rises from phase five to sample");
        $display("test divider alignment done");
        conclude();
    end
endmodule
